//--- hdl/icd_capture.sv
/*
 * Input capture module with its own 16-bit counter, capture FIFO and cascade.
 * Assumes all inputs synchronous to core_clk_i; time base ticks, sync events and
 * the cascade carry from the odd partner arrive as one-cycle pulses.
 */
// Overview of operation
// - Free-running counter counts up on time base ticks, wrapping FFFFh to 0000h.
// - Each qualifying capture event pushes the present counter value into FIFO, unless it is full and not being read.
// - Synchronous mode captures at once; sync source event resets the counter.
// - Trigger mode holds counter stopped until selected source event arrives.
// - Source zero and trigger clear is free-running; nonzero selects sync or trigger.
// - Source zero with trigger select set waits for software to set trigger status.
// - Cascaded odd module gives low word; its wraps increment the even counter.
// - Cascade acts only when cascade enable is set in both modules.
// - Even module with trigger select clear runs synchronously with the odd module.
// - Synchronous mode holds the module in reset until its own sync source is enabled.
// - Buffer-not-empty bit reads one while FIFO holds a value, hardware cleared.
// - Read-only overflow flag reports that a capture overflow happened.
// - Interrupt after every first to fourth capture for count field 00 to 11; every-edge mode interrupts on each capture.
// - Mode field selects off, every edge, falling, rising, every 4th or 16th rise.
// - Mode 111 makes the pin a rising-edge wake interrupt in Sleep or Idle only.
// - Time base select picks system clock or one of five timers; 101, 110 reserved.
// - Stop-in-idle set halts the module during CPU Idle.
// - Trigger status set by hardware or software; while clear counter held zero.
// - Source field maps codes to compare, capture, timer, comparator, converter sources.
// - Captured values are held in a four-entry FIFO.
`timescale 1ns/1ps
`default_nettype none
`include "icd_defs.svh"
module icd_capture import icd_pkg::*; #(
    parameter int DEPTH = `ICD_FIFO_DEPTH,
    parameter bit ODD_MODULE = 1'b1
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    input wire logic capture_input_pin_i,
    input wire logic [4:0] timer_tick_i,
    input wire logic [31:0] sync_event_i,
    input wire logic [31:0] sync_enabled_i,
    input wire logic cpu_idle_i,
    input wire logic cpu_sleep_i,
    input wire logic partner_cascade_i,
    input wire logic partner_wrap_i,
    output logic wrap_o,
    output logic cascade_o,
    output logic capture_irq_o,
    output logic [15:0] capture_counter_o
);
    typedef struct packed {
        logic [15:0] ctl1;
        logic [15:0] ctl2;
        logic [15:0] cnt;
        logic pin_q;
        logic [3:0] pre;
        logic [1:0] ici_cnt;
        logic ov;
        logic [15:0] rdata;
        logic irq;
        logic wrap;
    } icd_st_type;
    icd_st_type st, next_st;

    icd_fifo_if fif();
    icd_fifo #(.DEPTH(DEPTH)) u_fifo (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .fif(fif)
    );

    icd_mode_type mode;
    logic [4:0] src;
    logic trig_sel;
    logic [2:0] tsel;
    logic cascaded;
    logic tick;
    logic src_event;
    logic src_on;
    logic halted;
    logic rise;
    logic fall;
    logic edge_hit;
    logic cap_ev;
    logic held;
    logic run;
    logic rd_buf;
    logic wr1;
    logic wr2;
    logic sync_mode;
    logic trig_mode;

    assign mode = icd_mode_type'(st.ctl1[2:0]);
    assign src = st.ctl2[4:0];
    assign tsel = st.ctl1[`ICD_TSEL_LSB +: 3];
    assign cascaded = st.ctl2[`ICD_CASC_BIT] && partner_cascade_i;
    // Even half of a pair ignores its trigger select and follows the odd half's sync
    assign trig_sel = st.ctl2[`ICD_TRIG_SEL_BIT] && !(cascaded && !ODD_MODULE);
    assign sync_mode = (src != `ICD_SYNC_NONE) && !trig_sel;
    assign trig_mode = trig_sel;
    assign src_event = sync_event_i[src] && (src != `ICD_SYNC_NONE);
    assign src_on = sync_enabled_i[src];
    assign halted = (mode == ICD_MODE_OFF) || (mode == ICD_MODE_UNUSED)
        || (st.ctl1[`ICD_SIDL_BIT] && cpu_idle_i);
    // Time base: codes 0..4 are Timer3,2,4,5,1; 7 is the core clock; 5,6 stall
    always_comb begin
        unique case (tsel)
            3'h0: tick = timer_tick_i[2];
            3'h1: tick = timer_tick_i[1];
            3'h2: tick = timer_tick_i[3];
            3'h3: tick = timer_tick_i[4];
            3'h4: tick = timer_tick_i[0];
            3'h7: tick = 1'b1;
            default: tick = 1'b0;
        endcase
    end
    // Synchronous mode waits for its source to be enabled
    assign held = sync_mode && !src_on;
    assign run = !halted && !held && (!trig_mode || st.ctl2[`ICD_TRIG_STAT_BIT]);
    assign rise = capture_input_pin_i && !st.pin_q;
    assign fall = !capture_input_pin_i && st.pin_q;
    always_comb begin
        unique case (mode)
            ICD_MODE_EVERY: edge_hit = rise || fall;
            ICD_MODE_FALL: edge_hit = fall;
            ICD_MODE_RISE, ICD_MODE_RISE4, ICD_MODE_RISE16: edge_hit = rise;
            default: edge_hit = 1'b0;
        endcase
    end
    assign rd_buf = rd_i && (addr_i == `ICD_OFF_BUF);
    assign wr1 = wr_i && (addr_i == `ICD_OFF_CTRL_ONE);
    assign wr2 = wr_i && (addr_i == `ICD_OFF_CTRL_TWO);

    always_comb begin
        next_st = st;
        cap_ev = 1'b0;
        next_st.pin_q = capture_input_pin_i;
        next_st.irq = 1'b0;
        next_st.wrap = 1'b0;
        if (wr1) begin
            next_st.ctl1 = (wdata_i & `ICD_CTRL_ONE_WMASK)
                | (st.ctl1 & ~`ICD_CTRL_ONE_WMASK);
            next_st.pre = '0;
            next_st.ici_cnt = '0;
        end
        if (wr2) begin
            // Software may set trigger status but a written zero disarms it
            next_st.ctl2 = (wdata_i & `ICD_CTRL_TWO_WMASK)
                | (st.ctl2 & ~`ICD_CTRL_TWO_WMASK);
        end
        if (trig_mode && src_event && !held) begin
            next_st.ctl2[`ICD_TRIG_STAT_BIT] = 1'b1;
        end
        if (mode == ICD_MODE_WAKE) begin
            next_st.irq = rise && (cpu_sleep_i || cpu_idle_i);
        end else if (!run) begin
            if (held || (trig_mode && !st.ctl2[`ICD_TRIG_STAT_BIT])) begin
                next_st.cnt = '0;
            end
        end else begin
            if (sync_mode && src_event) begin
                next_st.cnt = '0;
            end else if (cascaded && !ODD_MODULE) begin
                next_st.cnt = st.cnt + 16'(partner_wrap_i);
            end else if (tick) begin
                next_st.cnt = st.cnt + 16'h0001;
                next_st.wrap = (st.cnt == 16'hffff);
            end
            if (edge_hit) begin
                unique case (mode)
                    ICD_MODE_RISE4: begin
                        next_st.pre = (st.pre[1:0] == 2'h3) ? 4'h0 : st.pre + 4'h1;
                        cap_ev = (st.pre[1:0] == 2'h3);
                    end
                    ICD_MODE_RISE16: begin
                        next_st.pre = st.pre + 4'h1;
                        cap_ev = (st.pre == 4'hf);
                    end
                    default: cap_ev = 1'b1;
                endcase
            end
            if (cap_ev) begin
                if (mode == ICD_MODE_EVERY) begin
                    next_st.irq = 1'b1;
                end else begin
                    next_st.ici_cnt = (st.ici_cnt == st.ctl1[`ICD_ICI_LSB +: 2])
                        ? 2'h0 : st.ici_cnt + 2'h1;
                    next_st.irq = (st.ici_cnt == st.ctl1[`ICD_ICI_LSB +: 2]);
                end
                if (fif.full && !rd_buf) next_st.ov = 1'b1;
            end
        end
        // Overflow holds until the FIFO drains; the set wins over the clear
        if (fif.empty && !(cap_ev && fif.full)) next_st.ov = 1'b0;
        if (mode == ICD_MODE_OFF) next_st.ov = 1'b0;
        unique case (addr_i)
            `ICD_OFF_CTRL_ONE: next_st.rdata = {st.ctl1[15:5], st.ov, !fif.empty,
                st.ctl1[2:0]};
            `ICD_OFF_CTRL_TWO: next_st.rdata = st.ctl2;
            `ICD_OFF_BUF: next_st.rdata = fif.empty ? 16'h0000 : fif.head;
            `ICD_OFF_CTRL_X: next_st.rdata = st.cnt;
            default: next_st.rdata = 16'h0000;
        endcase
        if (!rd_i) next_st.rdata = 16'h0000;
    end

    // A capture pushes while a read pops in the same cycle, so full never drops a capture made during a read
    assign fif.push = cap_ev && (!fif.full || rd_buf);
    assign fif.push_data = st.cnt;
    assign fif.pop = rd_buf && !fif.empty;
    assign fif.flush = (mode == ICD_MODE_OFF);

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st <= '0;
            st.ctl1 <= `ICD_CTRL_ONE_RST;
            st.ctl2 <= `ICD_CTRL_TWO_RST;
        end else begin
            st <= next_st;
        end
    end

    assign rdata_o = st.rdata;
    assign capture_irq_o = st.irq;
    assign wrap_o = st.wrap;
    assign cascade_o = st.ctl2[`ICD_CASC_BIT];
    assign capture_counter_o = st.cnt;

    a_wrap_to_zero: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        wrap_o |-> capture_counter_o == 16'h0000)
        else $error("counter did not wrap to zero");
    a_capture_pushes: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (cap_ev && !fif.full) |=> !fif.empty)
        else $error("capture not stored");
    a_sync_reset: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (run && sync_mode && src_event && !wr1 && !wr2) |=> capture_counter_o == 16'h0000)
        else $error("sync event did not clear counter");
    a_trig_stopped: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (trig_mode && !st.ctl2[`ICD_TRIG_STAT_BIT] && mode != ICD_MODE_WAKE)
        |=> capture_counter_o == 16'h0000)
        else $error("counter ran before trigger");
    a_bne_tracks: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (rd_i && addr_i == `ICD_OFF_CTRL_ONE) |=> rdata_o[`ICD_BNE_BIT] == !$past(fif.empty))
        else $error("buffer flag wrong");
    a_ov_on_full: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (cap_ev && fif.full && !rd_buf) |=> st.ov)
        else $error("overflow not flagged");
    a_held_sync: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (held && mode != ICD_MODE_WAKE) |=> capture_counter_o == 16'h0000)
        else $error("counter ran before sync source enabled");
    a_idle_halt: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (st.ctl1[`ICD_SIDL_BIT] && cpu_idle_i && !wr1 && !wr2)
        |=> $stable(capture_counter_o) && !fif.push)
        else $error("module ran in idle");
    a_every_edge_irq: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (cap_ev && mode == ICD_MODE_EVERY) |=> capture_irq_o)
        else $error("edge mode missed interrupt");
endmodule
`default_nettype wire

//--- common/icd_defs.svh
/*
 * Register offsets, field positions, reset values and codes of the input capture block.
 * Assumes inclusion by bare name from the capture and FIFO design files.
 */
`ifndef ICD_DEFS_SVH
`define ICD_DEFS_SVH
`define ICD_OFF_CTRL_ONE 4'h0
`define ICD_OFF_CTRL_TWO 4'h1
`define ICD_OFF_BUF 4'h2
`define ICD_OFF_CTRL_X 4'h3
`define ICD_CTRL_ONE_RST 16'h0000
`define ICD_CTRL_TWO_RST 16'h000d
`define ICD_CTRL_ONE_WMASK 16'h3c67
`define ICD_CTRL_TWO_WMASK 16'h01df
`define ICD_SIDL_BIT 13
`define ICD_TSEL_LSB 10
`define ICD_ICI_LSB 5
`define ICD_OV_BIT 4
`define ICD_BNE_BIT 3
`define ICD_CASC_BIT 8
`define ICD_TRIG_SEL_BIT 7
`define ICD_TRIG_STAT_BIT 6
`define ICD_FIFO_DEPTH 4
`define ICD_SYNC_NONE 5'h00
`define ICD_SYNC_CMP_LO 5'h18
`define ICD_SYNC_CTU 5'h1c
`define ICD_TSEL_SYSCLK 3'h7
`endif

//--- common/icd_pkg.sv
/*
 * Types for the input capture block.
 * Assumes icd_defs.svh is on the include path.
 */
package icd_pkg;
    typedef enum logic [2:0] {
        ICD_MODE_OFF, ICD_MODE_EVERY, ICD_MODE_FALL, ICD_MODE_RISE,
        ICD_MODE_RISE4, ICD_MODE_RISE16, ICD_MODE_UNUSED, ICD_MODE_WAKE
    } icd_mode_type;
endpackage

//--- common/icd_fifo_if.sv
/*
 * Push/pop interface between the capture core and its FIFO.
 * Assumes one clock shared by both modules.
 */
`timescale 1ns/1ps
`default_nettype none
interface icd_fifo_if;
    logic push;
    logic [15:0] push_data;
    logic pop;
    logic flush;
    logic [15:0] head;
    logic full;
    logic empty;
    modport owner (output push, push_data, pop, flush, input head, full, empty);
    modport store (input push, push_data, pop, flush, output head, full, empty);
endinterface
`default_nettype wire

//--- hdl/icd_fifo.sv
/*
 * Four-entry capture value store.
 * Assumes the owner never pops while empty; push while full is dropped unless a pop
 * in the same cycle frees the slot.
 */
`timescale 1ns/1ps
`default_nettype none
`include "icd_defs.svh"
module icd_fifo import icd_pkg::*; #(
    parameter int DEPTH = `ICD_FIFO_DEPTH
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    icd_fifo_if.store fif
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] rd;
        logic [AW-1:0] wr;
        logic [AW:0] cnt;
    } icd_fst_type;
    icd_fst_type st, next_st;
    logic [15:0] mem [DEPTH];
    logic do_push;
    logic do_pop;

    assign do_pop = fif.pop && (st.cnt != '0);
    // A pop in the same cycle frees the head slot, so a capture into a full store is kept
    assign do_push = fif.push && ((st.cnt != (AW+1)'(DEPTH)) || do_pop);
    assign fif.full = (st.cnt == (AW+1)'(DEPTH));
    assign fif.empty = (st.cnt == '0);
    assign fif.head = mem[st.rd];

    always_comb begin
        next_st = st;
        if (fif.flush) begin
            next_st = '0;
        end else begin
            if (do_push) next_st.wr = st.wr + 1'b1;
            if (do_pop) next_st.rd = st.rd + 1'b1;
            next_st.cnt = st.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) st <= '0;
        else st <= next_st;
    end

    always_ff @(posedge core_clk_i) begin
        if (do_push && !fif.flush) mem[st.wr] <= fif.push_data;
    end
endmodule
`default_nettype wire

//--- tb/icd_far.sv
/*
 * Far-side model: capture pin, timer ticks and sync sources.
 * Assumes one clock shared with the capture block; tasks are called by the bench.
 */
`timescale 1ns/1ps
`default_nettype none
module icd_far (
    input wire logic core_clk_i,
    output logic pin_o,
    output logic [4:0] tick_o,
    output logic [31:0] ev_o,
    output logic [31:0] en_o
);
    initial begin
        pin_o = 1'b0;
        tick_o = 5'h00;
        ev_o = 32'h0;
        en_o = 32'hffffffff;
    end
    // One idle edge after each change so the block sees every level
    task automatic edge_to(input logic lv);
        @(posedge core_clk_i);
        pin_o <= lv;
        @(posedge core_clk_i);
    endtask
    // Tick held high for n edges gives n counts
    task automatic ticks(input int b, input int n);
        @(posedge core_clk_i);
        tick_o <= 5'(5'h01 << b);
        repeat (n) @(posedge core_clk_i);
        tick_o <= 5'h00;
    endtask
    // Source enable level, changed one edge after the call
    task automatic set_en(input int c, input logic lv);
        @(posedge core_clk_i);
        en_o[c] <= lv;
    endtask
    // Only timer codes are used as sync sources here
    task automatic event_on(input int c);
        @(posedge core_clk_i);
        ev_o[c] <= 1'b1;
        @(posedge core_clk_i);
        ev_o <= 32'h0;
    endtask
endmodule
`default_nettype wire

//--- tb/tb.sv
/*
 * Self-checking bench for the capture block.
 * Assumes the far-side model drives pin, ticks and sync sources.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic core_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [3:0] addr_i = 4'h0;
    logic [15:0] wdata_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic cpu_idle_i = 1'b0;
    logic cpu_sleep_i = 1'b0;
    logic hi = 1'b0;
    logic [15:0] rdata_o;
    logic [15:0] v;
    logic pin;
    logic irq;
    logic wrap;
    logic [4:0] tick;
    logic [31:0] ev;
    logic [31:0] en;
    logic casc;
    logic casc_hi;
    logic [15:0] cnt;
    logic [15:0] cnt_hi;
    logic [15:0] rdata_hi;
    int n_fail = 0;
    int tests_run = 0;
    int n_irq = 0;
    int n_wrap = 0;
    int md[5] = '{1, 2, 3, 4, 5};
    int nr[5] = '{1, 1, 1, 4, 16};
    always #5 core_clk_i = ~core_clk_i;
    icd_far far (.core_clk_i(core_clk_i), .pin_o(pin), .tick_o(tick), .ev_o(ev), .en_o(en));
    // Odd half takes the bus while hi is low, the even half while it is high
    icd_capture DUT (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i && !hi), .rd_i(rd_i && !hi), .rdata_o(rdata_o),
        .capture_input_pin_i(pin), .timer_tick_i(tick), .sync_event_i(ev),
        .sync_enabled_i(en), .cpu_idle_i(cpu_idle_i), .cpu_sleep_i(cpu_sleep_i),
        .partner_cascade_i(casc_hi), .partner_wrap_i(1'b0), .wrap_o(wrap), .cascade_o(casc),
        .capture_irq_o(irq), .capture_counter_o(cnt));
    icd_capture #(.ODD_MODULE(1'b0)) DUT_hi (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i && hi), .rd_i(rd_i && hi),
        .rdata_o(rdata_hi), .capture_input_pin_i(pin), .timer_tick_i(tick),
        .sync_event_i(ev), .sync_enabled_i(en), .cpu_idle_i(cpu_idle_i),
        .cpu_sleep_i(cpu_sleep_i), .partner_cascade_i(casc), .partner_wrap_i(wrap),
        .wrap_o(), .cascade_o(casc_hi), .capture_irq_o(), .capture_counter_o(cnt_hi));
    always @(posedge core_clk_i) begin
        if (irq === 1'b1) n_irq++;
        if (wrap === 1'b1) n_wrap++;
    end
    task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        tests_run++;
        if (s !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge core_clk_i);
        wr_i <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge core_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge core_clk_i);
        rd_i <= 1'b0;
        #1 v = hi ? rdata_hi : rdata_o;
    endtask
    task automatic cap();
        far.edge_to(1'b1);
        far.edge_to(1'b0);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        n_fail++;
        give_verdict();
    end
    initial begin
        repeat (5) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        rd(4'h0);
        chk("ctl1 reset", v, 16'h0000);
        rd(4'h1);
        chk("ctl2 reset", v, 16'h000d);
        hi <= 1'b1;
        // Even half first; its own trigger select is set but must be overridden
        wr(4'h1, 16'h0180);
        wr(4'h0, 16'h1003);
        hi <= 1'b0;
        wr(4'h1, 16'h0100);
        wr(4'h0, 16'h1003);
        far.ticks(0, 5);
        for (int i = 0; i < 5; i++) begin
            cap();
            far.ticks(0, 1);
        end
        rd(4'h0);
        chk("flags full", v, 16'h101b);
        for (int i = 0; i < 4; i++) begin
            rd(4'h2);
            chk("fifo entry", v, 16'(5 + i));
            hi <= 1'b1;
            rd(4'h2);
            chk("fifo high entry", v, 16'h0000);
            hi <= 1'b0;
        end
        rd(4'h0);
        chk("flags empty", v, 16'h1003);
        rd(4'h2);
        chk("empty read", v, 16'h0000);
        far.ticks(0, 65528);
        cap();
        rd(4'h2);
        chk("after wrap", v, 16'h0002);
        hi <= 1'b1;
        rd(4'h2);
        chk("high word", v, 16'h0001);
        hi <= 1'b0;
        chk("high counter", cnt_hi, 16'h0001);
        chk("cascade pair", 16'({casc_hi, casc}), 16'h0003);
        chk("wrap pulses", 16'(n_wrap), 16'h0001);
        $display("fifo and counter test done");
        for (int i = 0; i < 5; i++) begin
            wr(4'h0, 16'h0000);
            wr(4'h0, 16'(16'h1000 | md[i]));
            repeat (nr[i] - 1) cap();
            far.edge_to(1'b1);
            rd(4'h0);
            chk("after rise", v & 16'h0008, (md[i] == 2) ? 16'h0 : 16'h8);
            far.edge_to(1'b0);
            rd(4'h0);
            chk("after fall", v & 16'h0008, 16'h0008);
        end
        $display("mode test done");
        for (int i = 0; i < 5; i++) begin
            wr(4'h0, 16'h0000);
            wr(4'h0, (i < 4) ? 16'(16'h1003 | (i << 5)) : 16'h1061);
            n_irq = 0;
            repeat (12) begin
                cap();
                rd(4'h2);
                rd(4'h2);
            end
            chk("irq count", 16'(n_irq), (i < 4) ? 16'(12 / (i + 1)) : 16'd24);
        end
        $display("interrupt test done");
        wr(4'h0, 16'h0000);
        far.set_en(11, 1'b0);
        wr(4'h1, 16'h000b);
        wr(4'h0, 16'h1003);
        far.ticks(0, 5);
        cap();
        chk("held count", cnt, 16'h0000);
        far.set_en(11, 1'b1);
        far.ticks(0, 5);
        far.event_on(11);
        far.ticks(0, 3);
        cap();
        chk("sync count", cnt, 16'h0003);
        rd(4'h2);
        chk("sync reset", v, 16'h0003);
        wr(4'h0, 16'h0000);
        wr(4'h1, 16'h008b);
        wr(4'h0, 16'h1003);
        far.ticks(0, 5);
        rd(4'h1);
        chk("trig waiting", v, 16'h008b);
        far.event_on(11);
        rd(4'h1);
        chk("trig status", v, 16'h00cb);
        far.ticks(0, 4);
        cap();
        rd(4'h2);
        chk("trig count", v, 16'h0004);
        wr(4'h0, 16'h0000);
        wr(4'h1, 16'h0080);
        wr(4'h0, 16'h1003);
        far.ticks(0, 3);
        wr(4'h1, 16'h00c0);
        far.ticks(0, 2);
        cap();
        rd(4'h2);
        chk("soft trig", v, 16'h0002);
        $display("sync and trigger test done");
        wr(4'h0, 16'h0000);
        wr(4'h1, 16'h0000);
        wr(4'h0, 16'h3003);
        cpu_idle_i <= 1'b1;
        cap();
        rd(4'h0);
        chk("idle halt", v, 16'h3003);
        cpu_idle_i <= 1'b0;
        wr(4'h0, 16'h0000);
        wr(4'h0, 16'hffff);
        rd(4'h0);
        chk("ctl1 mask", v, 16'h3c67);
        // Mode 111: a rise interrupts only while the core sleeps or idles
        n_irq = 0;
        cap();
        cpu_sleep_i <= 1'b1;
        cap();
        cpu_sleep_i <= 1'b0;
        chk("wake irq", 16'(n_irq), 16'h0001);
        wr(4'h1, 16'hffff);
        rd(4'h1);
        chk("ctl2 mask", v, 16'h01df);
        wr(4'h6, 16'hffff);
        rd(4'h6);
        chk("unmapped", v, 16'h0000);
        $display("register test done");
        give_verdict();
    end
endmodule
`default_nettype wire
